// ---- hlt_pkg.sv ----
// Shared constants, types and helpers for both ends of the host link.
// Contract
// [RULE1] Host I2C clock at most 400 kHz, even duty.
// [RULE2] Device resets I2C logic after SCL low 2 s.
// [RULE3] Device resets SPI when CS low, SCLK still 2 s.
// [RULE4] Host holds line low; device resets after 2 s.
// [RULE5] Host break 190 us, then 40 us recovery.
// [RULE6] Host writes one 0.5-50 us, zero 86-145 us low.
// [RULE7] Device accepts 86-145 us low as zero bit.
// [RULE8] Host bit cycle at least 190 us.
// [RULE9] Device one 32-50 us low, zero 80-145 us.
// [RULE10] Device bit cycle 190-250 us, nominally 205 us.
// [RULE11] Device waits 190 us before responding.
// [RULE12] Host waits 210 us after device releases line.
// [RULE13] Host leaves about 50 us between SPI transfers.
// [RULE14] Device may filter SPI pulses under 200 ns.
// [RULE15] Host SPI clock period at least 500 ns.
// [RULE16] Stuck timers restart on activity, count slow ticks.
package hlt_pkg;
  typedef logic [21:0] hlt_us_t;

  localparam int CLK_PERIOD_NS = 40;
  // Slow timebase: all link timers count 1 us ticks.
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;

  // Stuck-bus reset time, nominal 2 s within the 1.9 s to 2.1 s window.
  localparam hlt_us_t RST_US = 22'h1e8480;

  localparam hlt_us_t BREAK_US = 22'hbe;
  localparam hlt_us_t RECOV_US = 22'h28;
  localparam hlt_us_t HW1_MAX_US = 22'h32;
  localparam hlt_us_t HW0_MIN_US = 22'h56;
  localparam hlt_us_t HW0_MAX_US = 22'h91;
  localparam hlt_us_t HW1_US = 22'h14;
  localparam hlt_us_t HW0_US = 22'h6e;
  localparam hlt_us_t CYCH_US = 22'hc8;
  localparam hlt_us_t DW1_US = 22'h28;
  localparam hlt_us_t DW0_US = 22'h6e;
  localparam hlt_us_t CYCD_US = 22'hcd;
  localparam hlt_us_t RSPS_US = 22'hbe;
  localparam hlt_us_t TRND_US = 22'hd2;
  localparam hlt_us_t DW_SPLIT_US = 22'h41;
  localparam hlt_us_t RSP_TMO_US = 22'hfa0;
  localparam hlt_us_t TD_US = 22'h32;

  localparam int FILT_NS = 200;
  localparam int FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_MIN_NS = 500;
  localparam int SCK_HALF_CYC = (SCK_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_HALF_CYC = (1000000 / SCL_MAX_KHZ / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // SPI frame in half clock periods: lead, eight high phases, lag.
  localparam logic [4:0] SPI_P_FIRST = 5'h04;
  localparam logic [4:0] SPI_P_LAST = 5'h12;
  localparam logic [4:0] SPI_P_END = 5'h15;

  function automatic hlt_us_t inc_sat(input hlt_us_t v);
    return (v == '1) ? v : v + 22'h1;
  endfunction
endpackage

// ---- hlt_link_if.sv ----
// Pins joining the device end and the host end of the host link.
`timescale 1ns/1ps
interface hlt_link_if;
  logic ow_host_o;
  logic ow_host_oe;
  logic ow_dev_o;
  logic ow_dev_oe;
  logic one_wire_line;
  logic spi_sclk;
  logic spi_cs_n;
  logic spi_mosi;
  logic spi_miso;
  logic i2c_scl;

  // The line is pulled up; any enabled driver driving low wins.
  assign one_wire_line = ~((ow_host_oe & ~ow_host_o) | (ow_dev_oe & ~ow_dev_o));

  modport dev (
    input one_wire_line, spi_sclk, spi_cs_n, spi_mosi, i2c_scl,
    output ow_dev_o, ow_dev_oe, spi_miso
  );
  modport host (
    input one_wire_line, spi_miso,
    output ow_host_o, ow_host_oe, spi_sclk, spi_cs_n, spi_mosi, i2c_scl
  );
endinterface

// ---- hlt_dev.sv ----
// Device end: one-wire target, SPI receiver on the link clock, stuck-bus monitors.
`timescale 1ns/1ps
module hlt_dev #(
  parameter hlt_pkg::hlt_us_t RST_US = hlt_pkg::RST_US
) (
  input wire logic clk,
  input wire logic resetn,
  hlt_link_if.dev link,
  input wire logic spi_filt_en,
  input wire logic reply_en,
  input wire logic [7:0] reply_byte,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic tx_done,
  output logic spi_valid,
  output logic [7:0] spi_byte,
  output logic ow_reset,
  output logic i2c_reset,
  output logic spi_reset
);
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_WAIT, ST_TX_LOW, ST_TX_HIGH} hlt_dst_t;

  hlt_dst_t st_q;
  logic [4:0] pre_q;
  logic tick_q;
  logic [1:0] ow_sy_q;
  logic [1:0] scl_sy_q;
  logic [1:0] sck_sy_q;
  logic [1:0] cs_sy_q;
  logic [1:0] srdy_sy_q;
  logic ow_prev_q;
  logic srdy_p_q;
  logic sck_f_q;
  logic sck_p_q;
  logic [2:0] flt_q;
  hlt_pkg::hlt_us_t low_q;
  hlt_pkg::hlt_us_t tmr_q;
  hlt_pkg::hlt_us_t scl_q;
  hlt_pkg::hlt_us_t sck_q;
  logic spi_stuck_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [2:0] bit_q;
  logic oe_q;
  logic ow_rise;
  logic ow_stuck;
  logic bit_one;
  logic bit_ok;
  logic spi_clr;
  logic [2:0] sb_q;
  logic [7:0] ssh_q;
  logic srdy_q;

  // The slow tick keeps every link timer narrow and cheap. see [RULE16]
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pre_q <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (pre_q == 5'(hlt_pkg::TICK_CYC - 1));
      pre_q <= (pre_q == 5'(hlt_pkg::TICK_CYC - 1)) ? 5'h00 : pre_q + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ow_sy_q <= 2'h3;
      scl_sy_q <= 2'h3;
      sck_sy_q <= 2'h0;
      cs_sy_q <= 2'h3;
      ow_prev_q <= 1'b1;
    end else begin
      ow_sy_q <= {ow_sy_q[0], link.one_wire_line};
      scl_sy_q <= {scl_sy_q[0], link.i2c_scl};
      sck_sy_q <= {sck_sy_q[0], link.spi_sclk};
      cs_sy_q <= {cs_sy_q[0], link.spi_cs_n};
      ow_prev_q <= ow_sy_q[1];
    end
  end

  assign ow_rise = ~ow_prev_q & ow_sy_q[1];
  assign ow_stuck = (low_q >= RST_US);
  assign bit_one = (low_q <= hlt_pkg::HW1_MAX_US);
  assign bit_ok = bit_one || (low_q >= hlt_pkg::HW0_MIN_US && low_q <= hlt_pkg::HW0_MAX_US);

  // Low-time counter; it still holds the finished width in the cycle of the rise.
  always_ff @(posedge clk) begin
    if (!resetn || ow_sy_q[1]) begin
      low_q <= '0;
    end else if (tick_q) begin
      low_q <= hlt_pkg::inc_sat(low_q); // see [RULE16]
    end
  end

  // I2C clock low watch, restarted by every high level.
  always_ff @(posedge clk) begin
    if (!resetn || scl_sy_q[1]) begin
      scl_q <= '0;
    end else if (tick_q) begin
      scl_q <= hlt_pkg::inc_sat(scl_q); // see [RULE16]
    end
  end

  // Glitch filter on the SPI clock as seen by the stuck monitor. see [RULE14]
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sck_f_q <= 1'b0;
      sck_p_q <= 1'b0;
      flt_q <= 3'h0;
    end else begin
      sck_p_q <= sck_f_q;
      if (sck_sy_q[1] == sck_f_q) begin
        flt_q <= 3'h0;
      end else if (!spi_filt_en || flt_q == 3'(hlt_pkg::FILT_CYC - 1)) begin
        sck_f_q <= sck_sy_q[1];
        flt_q <= 3'h0;
      end else begin
        flt_q <= flt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || cs_sy_q[1] || sck_f_q != sck_p_q) begin
      sck_q <= '0;
    end else if (tick_q) begin
      sck_q <= hlt_pkg::inc_sat(sck_q); // see [RULE3] see [RULE16]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ow_reset <= 1'b0;
      i2c_reset <= 1'b0;
      spi_reset <= 1'b0;
      spi_stuck_q <= 1'b0;
    end else begin
      ow_reset <= tick_q && !ow_sy_q[1] && low_q == RST_US - 22'h1; // see [RULE4]
      i2c_reset <= tick_q && !scl_sy_q[1] && scl_q == RST_US - 22'h1; // see [RULE2]
      spi_reset <= tick_q && !cs_sy_q[1] && sck_q == RST_US - 22'h1; // see [RULE3]
      spi_stuck_q <= !cs_sy_q[1] && sck_q >= RST_US; // see [RULE3]
    end
  end

  // SPI receiver on the host's clock. Chip select high or a stuck bus clears it,
  // since the clock may never toggle again to do so.
  assign spi_clr = link.spi_cs_n | spi_stuck_q;

  always_ff @(posedge link.spi_sclk or posedge spi_clr) begin
    if (spi_clr) begin
      sb_q <= 3'h0;
      ssh_q <= 8'h00;
      srdy_q <= 1'b0;
    end else begin
      ssh_q <= {ssh_q[6:0], link.spi_mosi};
      sb_q <= sb_q + 3'h1;
      if (sb_q == 3'h7) begin
        srdy_q <= 1'b1;
      end
    end
  end

  // The shifted bits come back out seven clocks later, until chip select high clears them.
  assign link.spi_miso = ssh_q[7];

  // The byte is stable while the ready level stands, so it may be sampled here.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      srdy_sy_q <= 2'h0;
      srdy_p_q <= 1'b0;
      spi_valid <= 1'b0;
      spi_byte <= 8'h00;
    end else begin
      srdy_sy_q <= {srdy_sy_q[0], srdy_q};
      srdy_p_q <= srdy_sy_q[1];
      spi_valid <= srdy_sy_q[1] & ~srdy_p_q;
      if (srdy_sy_q[1] & ~srdy_p_q) begin
        spi_byte <= ssh_q;
      end
    end
  end

  // One-wire engine: break, eight host bits LSB first, then an optional reply.
  always_ff @(posedge clk) begin
    if (!resetn || ow_stuck) begin
      st_q <= ST_IDLE; // see [RULE4]
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      bit_q <= 3'h0;
      tmr_q <= '0;
      oe_q <= 1'b0;
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
      tx_done <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      tx_done <= 1'b0;
      if (tick_q) begin
        tmr_q <= hlt_pkg::inc_sat(tmr_q);
      end
      case (st_q)
        ST_IDLE, ST_RX: begin
          if (ow_rise) begin
            if (low_q >= hlt_pkg::BREAK_US) begin
              st_q <= ST_RX;
              bit_q <= 3'h0;
            end else if (st_q == ST_RX && bit_ok) begin
              sh_q <= {bit_one, sh_q[7:1]}; // see [RULE7]
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7) begin
                rx_valid <= 1'b1;
                rx_byte <= {bit_one, sh_q[7:1]};
                tx_q <= reply_byte;
                tmr_q <= '0;
                st_q <= reply_en ? ST_WAIT : ST_IDLE;
              end
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_WAIT: begin
          if (tmr_q > hlt_pkg::RSPS_US) begin
            st_q <= ST_TX_LOW; // see [RULE11]
            tmr_q <= '0;
            bit_q <= 3'h0;
            oe_q <= 1'b1;
          end
        end
        ST_TX_LOW: begin
          if (tmr_q >= (tx_q[0] ? hlt_pkg::DW1_US : hlt_pkg::DW0_US)) begin
            st_q <= ST_TX_HIGH; // see [RULE9]
            oe_q <= 1'b0;
          end
        end
        ST_TX_HIGH: begin
          if (tmr_q >= hlt_pkg::CYCD_US) begin
            tmr_q <= '0; // see [RULE10]
            if (bit_q == 3'h7) begin
              st_q <= ST_IDLE;
              tx_done <= 1'b1;
            end else begin
              tx_q <= {1'b0, tx_q[7:1]};
              bit_q <= bit_q + 3'h1;
              oe_q <= 1'b1;
              st_q <= ST_TX_LOW;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign link.ow_dev_o = 1'b0;
  assign link.ow_dev_oe = oe_q;
endmodule

// ---- hlt_host.sv ----
// Host end: byte FIFO, one-wire controller, SPI and I2C clock generators.
`timescale 1ns/1ps
module hlt_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;

  // The extra pointer bit tells full from empty.
  assign in_ready = (wp_q ^ rp_q) != {1'b1, {AW{1'b0}}};
  assign out_valid = wp_q != rp_q;
  assign out_data = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wp_q <= wp_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule

module hlt_host #(
  parameter hlt_pkg::hlt_us_t RST_US = hlt_pkg::RST_US
) (
  input wire logic clk,
  input wire logic resetn,
  hlt_link_if.host link,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_byte,
  output logic rsp_valid,
  output logic [7:0] rsp_byte,
  output logic rsp_timeout,
  input wire logic bus_reset_req,
  output logic ow_busy,
  input wire logic spi_req,
  input wire logic [7:0] spi_wbyte,
  output logic spi_busy,
  input wire logic i2c_run
);
  typedef enum logic [2:0] {HS_IDLE, HS_RST, HS_BRK, HS_REC, HS_LOW, HS_HIGH, HS_RX, HS_TRND} hlt_hst_t;
  typedef enum logic [1:0] {SP_IDLE, SP_XFER, SP_GAP} hlt_sst_t;

  hlt_hst_t st_q;
  hlt_sst_t sst_q;
  logic [4:0] pre_q;
  logic tick_q;
  logic [1:0] ow_sy_q;
  logic ow_prev_q;
  hlt_pkg::hlt_us_t tmr_q;
  hlt_pkg::hlt_us_t gap_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic oe_q;
  logic pop_q;
  logic f_valid;
  logic [7:0] f_data;
  logic [2:0] sdiv_q;
  logic [4:0] sph_q;
  logic [4:0] sp_n;
  logic [7:0] ssh_q;
  logic sclk_q;
  logic cs_n_q;
  logic mosi_q;
  logic [5:0] scl_div_q;
  logic scl_q;

  hlt_fifo #(.W(8), .D(8)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_byte),
    .out_valid(f_valid),
    .out_ready(pop_q),
    .out_data(f_data)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pre_q <= 5'h00;
      tick_q <= 1'b0;
      ow_sy_q <= 2'h3;
      ow_prev_q <= 1'b1;
    end else begin
      tick_q <= (pre_q == 5'(hlt_pkg::TICK_CYC - 1));
      pre_q <= (pre_q == 5'(hlt_pkg::TICK_CYC - 1)) ? 5'h00 : pre_q + 5'h01;
      ow_sy_q <= {ow_sy_q[0], link.one_wire_line};
      ow_prev_q <= ow_sy_q[1];
    end
  end

  // One-wire controller; it drains the FIFO only between transactions.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= HS_IDLE;
      tmr_q <= '0;
      sh_q <= 8'h00;
      bit_q <= 3'h0;
      oe_q <= 1'b0;
      pop_q <= 1'b0;
      ow_busy <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_byte <= 8'h00;
      rsp_timeout <= 1'b0;
    end else begin
      pop_q <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_timeout <= 1'b0;
      ow_busy <= (st_q != HS_IDLE);
      if (tick_q) begin
        tmr_q <= hlt_pkg::inc_sat(tmr_q);
      end
      case (st_q)
        HS_IDLE: begin
          tmr_q <= '0;
          bit_q <= 3'h0;
          if (bus_reset_req) begin
            oe_q <= 1'b1;
            st_q <= HS_RST;
          end else if (f_valid) begin
            pop_q <= 1'b1;
            sh_q <= f_data;
            oe_q <= 1'b1;
            st_q <= HS_BRK;
          end
        end
        HS_RST: begin
          // Held past the nominal time so a device with a late timer still resets.
          if (tmr_q >= RST_US + (RST_US >> 4)) begin
            oe_q <= 1'b0; // see [RULE4]
            st_q <= HS_IDLE;
          end
        end
        HS_BRK: begin
          // The first tick may come one cycle after the timer clears, so minimums wait one tick more.
          if (tmr_q > hlt_pkg::BREAK_US) begin
            oe_q <= 1'b0; // see [RULE5]
            tmr_q <= '0;
            st_q <= HS_REC;
          end
        end
        HS_REC: begin
          if (tmr_q > hlt_pkg::RECOV_US) begin
            oe_q <= 1'b1; // see [RULE5]
            tmr_q <= '0;
            st_q <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (tmr_q >= (sh_q[0] ? hlt_pkg::HW1_US : hlt_pkg::HW0_US)) begin
            oe_q <= 1'b0; // see [RULE6]
            st_q <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (tmr_q >= hlt_pkg::CYCH_US) begin
            tmr_q <= '0; // see [RULE8]
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_q <= HS_RX;
            end else begin
              sh_q <= {1'b0, sh_q[7:1]};
              oe_q <= 1'b1;
              st_q <= HS_LOW;
            end
          end
        end
        HS_RX: begin
          if (ow_sy_q[1] != ow_prev_q) begin
            tmr_q <= '0;
          end
          if (ow_sy_q[1] && !ow_prev_q) begin
            sh_q <= {tmr_q <= hlt_pkg::DW_SPLIT_US, sh_q[7:1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              rsp_valid <= 1'b1;
              rsp_byte <= {tmr_q <= hlt_pkg::DW_SPLIT_US, sh_q[7:1]};
              st_q <= HS_TRND;
            end
          end else if (ow_sy_q[1] && tmr_q >= hlt_pkg::RSP_TMO_US) begin
            rsp_timeout <= 1'b1;
            tmr_q <= '0;
            st_q <= HS_TRND;
          end
        end
        HS_TRND: begin
          if (tmr_q > hlt_pkg::TRND_US) begin
            st_q <= HS_IDLE; // see [RULE12]
          end
        end
        default: begin
          st_q <= HS_IDLE;
        end
      endcase
    end
  end

  // SPI controller: clock derived by division, period at least 500 ns. see [RULE15]
  assign sp_n = sph_q + 5'h01;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sst_q <= SP_IDLE;
      sdiv_q <= 3'h0;
      sph_q <= 5'h00;
      ssh_q <= 8'h00;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      gap_q <= '0;
      spi_busy <= 1'b0;
    end else begin
      case (sst_q)
        SP_IDLE: begin
          if (spi_req) begin
            sst_q <= SP_XFER;
            ssh_q <= spi_wbyte;
            mosi_q <= spi_wbyte[7];
            cs_n_q <= 1'b0;
            sdiv_q <= 3'h0;
            sph_q <= 5'h00;
            spi_busy <= 1'b1;
          end
        end
        SP_XFER: begin
          sdiv_q <= sdiv_q + 3'h1;
          if (sdiv_q == 3'(hlt_pkg::SCK_HALF_CYC - 1)) begin
            sdiv_q <= 3'h0;
            sph_q <= sp_n;
            sclk_q <= sp_n >= hlt_pkg::SPI_P_FIRST && sp_n <= hlt_pkg::SPI_P_LAST && !sp_n[0];
            if (sp_n[0] && sp_n > hlt_pkg::SPI_P_FIRST && sp_n < hlt_pkg::SPI_P_LAST) begin
              ssh_q <= {ssh_q[6:0], 1'b0};
              mosi_q <= ssh_q[6];
            end
            if (sp_n == hlt_pkg::SPI_P_END) begin
              cs_n_q <= 1'b1;
              gap_q <= '0;
              sst_q <= SP_GAP;
            end
          end
        end
        SP_GAP: begin
          if (tick_q) begin
            gap_q <= hlt_pkg::inc_sat(gap_q);
          end
          if (gap_q > hlt_pkg::TD_US) begin
            spi_busy <= 1'b0; // see [RULE13]
            sst_q <= SP_IDLE;
          end
        end
        default: begin
          sst_q <= SP_IDLE;
        end
      endcase
    end
  end

  // I2C clock, even duty, no faster than 400 kHz. see [RULE1]
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_div_q <= 6'h00;
      scl_q <= 1'b1;
    end else if (!i2c_run && scl_q) begin
      // A stop only parks the clock high, so a low phase is never cut short.
      scl_div_q <= 6'h00;
    end else if (scl_div_q == 6'(hlt_pkg::SCL_HALF_CYC - 1)) begin
      scl_div_q <= 6'h00;
      scl_q <= ~scl_q;
    end else begin
      scl_div_q <= scl_div_q + 6'h01;
    end
  end

  assign link.ow_host_o = 1'b0;
  assign link.ow_host_oe = oe_q;
  assign link.spi_sclk = sclk_q;
  assign link.spi_cs_n = cs_n_q;
  assign link.spi_mosi = mosi_q;
  assign link.i2c_scl = scl_q;
endmodule

// ---- hlt_link_assertions.sv ----
// Checker of the first host link: one-wire bit timing, turnaround gaps, clock limits, bus reset.
`timescale 1ns/1ps
module hlt_link_assertions #(
  parameter int RST_US = 300
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ow_host_oe,
  input wire logic ow_dev_oe,
  input wire logic one_wire_line,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic i2c_scl,
  input wire logic ow_reset
);
  localparam int US = hlt_pkg::TICK_CYC;
  localparam int RLO = RST_US * US * 19 / 20;
  localparam int RHI = RST_US * US * 21 / 20;
  // Gap counters start saturated so the first edge after reset never looks like a short gap.
  logic [23:0] line_lo_q, h_lo_q, d_lo_q, h_per_q, h_idle_q, d_per_q, d_idle_q, cs_hi_q, sck_per_q, scl_half_q;
  logic host_q, dev_q, sclk_q, cs_q, scl_q;

  function automatic logic [23:0] up(input logic [23:0] v);
    return (v == 24'hffffff) ? v : v + 24'h1;
  endfunction

  always_ff @(posedge clk) begin
    if (!resetn) begin
      {host_q, dev_q, sclk_q, cs_q, scl_q} <= 5'h03;
      {line_lo_q, h_lo_q, d_lo_q} <= '0;
      {h_per_q, h_idle_q, d_per_q, d_idle_q, cs_hi_q, sck_per_q, scl_half_q} <= '1;
    end else begin
      {host_q, dev_q, sclk_q, cs_q, scl_q} <= {ow_host_oe, ow_dev_oe, spi_sclk, spi_cs_n, i2c_scl};
      line_lo_q <= one_wire_line ? 24'h0 : up(line_lo_q);
      h_lo_q <= ow_host_oe ? up(h_lo_q) : 24'h0;
      d_lo_q <= ow_dev_oe ? up(d_lo_q) : 24'h0;
      h_per_q <= (ow_host_oe && !host_q) ? 24'h0 : up(h_per_q);
      h_idle_q <= (!ow_host_oe && host_q) ? 24'h0 : up(h_idle_q);
      d_per_q <= (ow_dev_oe && !dev_q) ? 24'h0 : up(d_per_q);
      d_idle_q <= (!ow_dev_oe && dev_q) ? 24'h0 : up(d_idle_q);
      cs_hi_q <= (spi_cs_n && !cs_q) ? 24'h0 : up(cs_hi_q);
      sck_per_q <= (spi_sclk && !sclk_q) ? 24'h0 : up(sck_per_q);
      scl_half_q <= (i2c_scl != scl_q) ? 24'h0 : up(scl_half_q);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence host_rise_s;
    $rose(ow_host_oe);
  endsequence
  sequence dev_rise_s;
    $rose(ow_dev_oe);
  endsequence

  line_reset_a: assert property (ow_reset |-> line_lo_q >= RLO && line_lo_q <= RHI)
    else $error("one-wire reset outside the stuck window");
  dev_bit_a: assert property ($fell(ow_dev_oe) |->
    (d_lo_q >= 32 * US && d_lo_q <= 50 * US) || (d_lo_q >= 80 * US && d_lo_q <= 145 * US))
    else $error("device low pulse has a bad width");
  dev_cycle_a: assert property (dev_rise_s |-> d_per_q >= 190 * US && (d_per_q <= 250 * US || d_per_q >= 1600 * US))
    else $error("device bit cycle out of range");
  reply_wait_a: assert property (dev_rise_s |-> h_idle_q >= 190 * US)
    else $error("device answered too soon");
  host_bit_a: assert property ($fell(ow_host_oe) |-> (h_lo_q >= 13 && h_lo_q <= 50 * US) ||
    (h_lo_q >= 86 * US && h_lo_q <= 145 * US) || h_lo_q >= 190 * US)
    else $error("host low pulse has a bad width");
  host_cycle_a: assert property (host_rise_s |-> h_per_q >= 190 * US)
    else $error("host bit cycle too short");
  break_recov_a: assert property (host_rise_s |-> h_idle_q >= 40 * US)
    else $error("host released the line too briefly");
  host_turn_a: assert property (host_rise_s |-> d_idle_q >= 210 * US)
    else $error("host drove too soon after the device");
  spi_gap_a: assert property ($fell(spi_cs_n) |-> cs_hi_q >= 50 * US)
    else $error("transfers too close together");
  sclk_period_a: assert property ($rose(spi_sclk) |-> sck_per_q >= 12)
    else $error("serial clock period too short");
  scl_half_a: assert property ($changed(i2c_scl) |-> scl_half_q >= 31)
    else $error("bus clock phase too short");
endmodule

// ---- testbench.sv ----
// Bench joining both link ends, plus a second device end whose pins are driven by hand.
`timescale 1ns/1ps
module testbench;
  localparam hlt_pkg::hlt_us_t RST = 22'h12c;
  localparam int RST_I = 32'h12c;
  localparam int RLO = RST_I * hlt_pkg::TICK_CYC * 19 / 20;
  localparam int RHI = RST_I * hlt_pkg::TICK_CYC * 21 / 20;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic filt_en = 1'b0, filt2_en = 1'b0, reply_en = 1'b0, tx_valid = 1'b0;
  logic bus_reset_req = 1'b0, spi_req = 1'b0, i2c_run = 1'b0;
  logic [7:0] reply_byte = 8'h00, tx_byte = 8'h00, spi_wbyte = 8'h00;
  logic rx_valid, tx_done, spi_valid, ow_reset, i2c_reset, spi_reset, i2c2_reset, spi2_reset;
  logic tx_ready, rsp_valid, rsp_timeout, ow_busy, spi_busy;
  logic [7:0] rx_byte, spi_byte, rsp_byte;
  int err_total = 0;
  int comparisons = 0;

  hlt_link_if u_link();
  hlt_link_if u_link2();
  hlt_dev #(.RST_US(RST)) u_hlt_dev (.clk(clk), .resetn(resetn), .link(u_link.dev), .spi_filt_en(filt_en),
    .reply_en(reply_en), .reply_byte(reply_byte), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_done(tx_done),
    .spi_valid(spi_valid), .spi_byte(spi_byte), .ow_reset(ow_reset), .i2c_reset(i2c_reset), .spi_reset(spi_reset));
  hlt_dev #(.RST_US(RST)) u_hlt_dev2 (.clk(clk), .resetn(resetn), .link(u_link2.dev), .spi_filt_en(filt2_en),
    .reply_en(1'b0), .reply_byte(8'h00), .rx_valid(), .rx_byte(), .tx_done(), .spi_valid(), .spi_byte(),
    .ow_reset(), .i2c_reset(i2c2_reset), .spi_reset(spi2_reset));
  hlt_host #(.RST_US(RST)) u_hlt_host (.clk(clk), .resetn(resetn), .link(u_link.host), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_byte(tx_byte), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_timeout(rsp_timeout),
    .bus_reset_req(bus_reset_req), .ow_busy(ow_busy), .spi_req(spi_req), .spi_wbyte(spi_wbyte),
    .spi_busy(spi_busy), .i2c_run(i2c_run));
  hlt_link_assertions #(.RST_US(RST_I)) u_hlt_link_assertions (.clk(clk), .resetn(resetn),
    .ow_host_oe(u_link.ow_host_oe), .ow_dev_oe(u_link.ow_dev_oe), .one_wire_line(u_link.one_wire_line),
    .spi_sclk(u_link.spi_sclk), .spi_cs_n(u_link.spi_cs_n), .i2c_scl(u_link.i2c_scl), .ow_reset(ow_reset));

  always #20 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Counts: %0d mismatches in %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic t_exchange();
    int n;
    reply_en = 1'b1;
    reply_byte = 8'hc3;
    tx_byte = 8'h5a;
    tx_valid = 1'b1;
    @(negedge clk);
    tx_valid = 1'b0;
    for (n = 0; n < 50000 && rx_valid !== 1'b1; n++) @(negedge clk);
    chk(rx_byte, 8'h5a);
    for (n = 0; n < 50000 && rsp_valid !== 1'b1; n++) @(negedge clk);
    chk(rsp_byte, 8'hc3);
    chk(rsp_timeout, 1'b0);
    for (n = 0; n < 10000 && tx_done !== 1'b1; n++) @(negedge clk);
    chk(tx_done, 1'b1);
    reply_en = 1'b0;
  endtask

  // Unfiltered glitches must restart the stuck timer; filtered ones must not.
  task automatic t_stray();
    int n;
    int p;
    u_link2.i2c_scl = 1'b0;
    for (n = 0; n < RHI + 500 && i2c2_reset !== 1'b1; n++) @(negedge clk);
    chk(n >= RLO && n <= RHI, 1'b1);
    u_link2.i2c_scl = 1'b1;
    for (p = 0; p < 2; p++) begin
      filt2_en = p[0];
      u_link2.spi_cs_n = 1'b0;
      for (n = 0; n < RHI + 500 && spi2_reset !== 1'b1; n++) begin
        u_link2.spi_sclk = (n % 2000) < 2;
        @(negedge clk);
      end
      chk(n >= RLO && n <= RHI, p[0]);
      u_link2.spi_cs_n = 1'b1;
      u_link2.spi_sclk = 1'b0;
      @(negedge clk);
    end
  endtask

  task automatic t_bus_reset();
    int n;
    bus_reset_req = 1'b1;
    for (n = 0; n < RHI + 10000 && ow_reset !== 1'b1; n++) @(negedge clk);
    chk(ow_reset, 1'b1);
    // The received byte is cleared one cycle after the reset pulse.
    @(negedge clk);
    chk(rx_byte, 8'h00);
    bus_reset_req = 1'b0;
    for (n = 0; n < RHI && ow_busy !== 1'b0; n++) @(negedge clk);
  endtask

  task automatic t_spi();
    int n;
    spi_wbyte = 8'ha6;
    spi_req = 1'b1;
    for (n = 0; n < 100 && spi_busy !== 1'b1; n++) @(negedge clk);
    spi_wbyte = 8'h3c;
    for (n = 0; n < 400 && spi_valid !== 1'b1; n++) @(negedge clk);
    chk(spi_byte, 8'ha6);
    @(negedge clk);
    for (n = 0; n < 3000 && spi_valid !== 1'b1; n++) @(negedge clk);
    chk(spi_byte, 8'h3c);
    spi_req = 1'b0;
    for (n = 0; n < 3000 && spi_busy !== 1'b0; n++) @(negedge clk);
  endtask

  // One byte leaves for the line at once, so nine pushes fit before the buffer refuses.
  task automatic t_fill();
    int n;
    int taken;
    taken = 0;
    tx_byte = 8'h11;
    tx_valid = 1'b1;
    for (n = 0; n < 20; n++) begin
      if (tx_ready === 1'b1) taken++;
      @(negedge clk);
    end
    tx_valid = 1'b0;
    chk(taken, 32'h9);
  endtask

  initial begin
    #(64'd150000 * hlt_pkg::CLK_PERIOD_NS);
    err_total++;
    test_done();
  end

  initial begin
    u_link2.ow_host_o = 1'b0;
    u_link2.ow_host_oe = 1'b0;
    u_link2.spi_sclk = 1'b0;
    u_link2.spi_cs_n = 1'b1;
    u_link2.spi_mosi = 1'b0;
    u_link2.i2c_scl = 1'b1;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    i2c_run = 1'b1;
    fork
      t_exchange();
      t_stray();
    join
    i2c_run = 1'b0;
    t_bus_reset();
    t_spi();
    t_fill();
    test_done();
  end
endmodule
